/* include/nicsc_pkg.sv */
// Constants shared by the transmit/receive status and command block.
// Assumes byte offsets as seen on the register access port.
package nicsc_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_TSD0 = 8'h10;
  localparam logic [7:0] OFF_EARLY_RECEIVE_FLAGS = 8'h36;
  localparam logic [7:0] OFF_CMD  = 8'h37;
  localparam logic [7:0] OFF_EE   = 8'h50;
  localparam logic [7:0] OFF_MIS  = 8'h5C;
  // Access size codes for a single byte and a full double word.
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_DW   = 2'h2;
  // Transmit descriptor status bit positions.
  localparam int B_CRS = 31;
  localparam int B_ABT = 30;
  localparam int B_OWC = 29;
  localparam int B_HB  = 28;
  localparam int B_NCC = 24;
  localparam int B_LVL = 16;
  localparam int B_TOK = 15;
  localparam int B_TUN = 14;
  localparam int B_OWN = 13;
  // Descriptor reset value and software-writable mask.
  localparam logic [31:0] TSD_RST   = 32'h0000_2000;
  localparam logic [31:0] TSD_WMASK = 32'h003F_3FFF;
  // Frame length limits and the minimum transmit start level.
  localparam logic [12:0] LONG_LIM  = 13'h0700;
  localparam logic [12:0] RUNT_LEN  = 13'h0040;
  localparam logic [12:0] OVER_LEN  = 13'h1000;
  localparam logic [11:0] START_MIN = 12'h008;
  // Early receive flag, command and prom bit positions.
  localparam int E_GOOD  = 3;
  localparam int E_BAD   = 2;
  localparam int E_OVW   = 1;
  localparam int E_HIT   = 0;
  localparam int C_RST   = 4;
  localparam int C_RX    = 3;
  localparam int C_TX    = 2;
  localparam int EE_MODE = 6;
  // Reset values of the small registers.
  localparam logic [7:0]  EARLY_RECEIVE_FLAGS_RST = 8'h00;
  localparam logic [15:0] MIS_RST  = 16'h0000;
  // Prom operating modes.
  localparam logic [1:0] EE_NORMAL = 2'h0;
  localparam logic [1:0] EE_LOAD   = 2'h1;
  localparam logic [1:0] EE_PROG   = 2'h2;
  localparam logic [1:0] EE_CFGWR  = 2'h3;
  // Timing: clock period, reload time and soft reset length.
  localparam int CLK_NS   = 50;
  localparam int LOAD_MS  = 2;
  localparam int LOAD_CYC = (LOAD_MS * 1000000) / CLK_NS;
  localparam int SRST_CYC = 4;
  // Sequencer states.
  typedef enum logic [1:0] {ST_RUN, ST_SRST, ST_LOAD} nicsc_state_e;
endpackage : nicsc_pkg

/* logic/nicsc_top.sv */
// Transmit/receive status words, early receive flags, command and
// prom mode registers of a fast ethernet controller.
// Assumes all inputs synchronous to ref_clk and pulse-style events.
// Notes on behaviour
// - Size write clears descriptor read-only status bits.
// - Soft reset zeroes status except done flag.
// - Flag carrier, abort, late collision; heartbeat only when not at 100 Mbps.
// - Report collision count in bits 27-24.
// - Start transmit at level or full frame.
// - Success only when complete without underrun.
// - Underrun sets its flag, success stays clear.
// - Done flag set when descriptor DMA ends.
// - Size field; long frames hold next descriptor.
// - Unknown protocol uses length register threshold.
// - Zero length register means no early interrupt.
// - Header flags multicast, unicast, broadcast; broadcast masks multicast.
// - Header flags symbol, runt, long, CRC, alignment.
// - Good/bad completion flags, write one clears.
// - Overwrite flag on pointer equality, write clears.
// - Threshold flag raises interrupt, clears at end.
// - Soft reset command disables paths, self-clears.
// - Reload mode runs 2 ms then normal.
// - Programming mode hands pins to software.
// - Fraction code selects sixteenths; zero none.
`timescale 1ns/100ps
module nicsc_top #(
  parameter int LOAD_CYCLES = nicsc_pkg::LOAD_CYC
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Register access port.
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [1:0]  reg_size,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // Transmit completion events.
  input  wire logic        tx_done,
  input  wire logic [1:0]  tx_idx,
  input  wire logic        tx_carrier_lost,
  input  wire logic        tx_aborted,
  input  wire logic        tx_late_coll,
  input  wire logic        tx_hb_fail,
  input  wire logic [3:0]  tx_coll_cnt,
  input  wire logic        tx_underrun,
  input  wire logic        dma_done,
  input  wire logic [1:0]  dma_idx,
  input  wire logic        speed_100,
  // Transmit FIFO state.
  input  wire logic [11:0] tx_fifo_bytes,
  input  wire logic        tx_frame_in_fifo,
  input  wire logic [1:0]  tx_cur_idx,
  output logic             tx_start,
  output logic             tx_queue_hold,
  // Receive frame progress.
  input  wire logic        rx_active,
  input  wire logic [12:0] rx_byte_cnt,
  input  wire logic [12:0] rx_frame_len,
  input  wire logic        rx_proto_known,
  input  wire logic [3:0]  rx_early_fraction,
  input  wire logic [15:0] local_wr_ptr,
  input  wire logic [15:0] host_read_pointer,
  input  wire logic        rx_ring_empty,
  // Receive completion with its status.
  input  wire logic        rx_done,
  input  wire logic        rx_mcast,
  input  wire logic        rx_ucast,
  input  wire logic        rx_bcast,
  input  wire logic        rx_bad_symbol,
  input  wire logic        rx_crc_err,
  input  wire logic        rx_align_err,
  output logic             rx_done_ready,
  output logic             rx_ok_int,
  output logic             rx_err_int,
  // Header status word toward the DMA.
  output logic             hdr_valid,
  input  wire logic        hdr_ready,
  output logic      [15:0] hdr_status,
  // Path control.
  output logic             rx_path_on,
  output logic             tx_path_on,
  output logic             fifo_reinit,
  output logic             net_disable,
  output logic             cfg_write_en,
  output logic             load_busy,
  // Serial prom pins.
  output logic             prom_select,
  output logic             prom_clock,
  output logic             prom_in,
  input  wire logic        prom_out
);

  // True when the access hits the given byte offset.
  function automatic logic at(input logic [7:0] a, input logic [7:0] o);
    at = (a == o);
  endfunction : at

  logic [31:0]  tsd_ff [4];      // Descriptor status words.
  logic [31:0]  nxt_tsd [4];     // Their next values.
  logic [3:0]   hold_v;          // Long frame still in DMA.
  logic [7:0]   early_receive_flags_ff;         // Early receive flags.
  logic [7:0]   nxt_early_receive_flags;        // Their next value.
  logic [15:0]  mis_ff;          // Early interrupt length.
  logic         rx_on_ff;        // Receive path enable.
  logic         tx_on_ff;        // Transmit path enable.
  logic [1:0]   mode_ff;         // Prom operating mode.
  logic [2:0]   pins_ff;         // Select, clock, data in.
  nicsc_pkg::nicsc_state_e st_ff; // Reset sequencer state.
  logic [15:0]  cnt_ff;          // Sequencer countdown.
  logic [31:0]  rdata_ff;        // Read data register.
  logic         fired_ff;        // Early event seen this frame.
  logic         ok_ff;           // Receive OK pulse.
  logic         err_ff;          // Receive error pulse.
  logic [15:0]  buf_ff [2];      // Header buffer entries.
  logic         wp_ff;           // Buffer write slot.
  logic         rp_ff;           // Buffer read slot.
  logic [1:0]   fill_ff;         // Buffer occupancy.

  // Decoded writes; descriptors only take full dword writes.
  logic       wr_tsd;
  logic [1:0] wr_idx;
  logic       wr_early_receive_flags;
  logic       wr_cmd;
  logic       wr_ee;
  logic       wr_mis;
  logic       run;
  logic       load_end;
  logic       clr_all;
  logic       srst_on;
  assign wr_tsd  = reg_wr && reg_size == nicsc_pkg::SZ_DW
                   && reg_addr[7:4] == nicsc_pkg::OFF_TSD0[7:4]
                   && reg_addr[1:0] == 2'h0;
  assign wr_idx  = reg_addr[3:2];
  assign wr_early_receive_flags = reg_wr && at(reg_addr, nicsc_pkg::OFF_EARLY_RECEIVE_FLAGS);
  assign wr_cmd  = reg_wr && at(reg_addr, nicsc_pkg::OFF_CMD);
  assign wr_ee   = reg_wr && at(reg_addr, nicsc_pkg::OFF_EE);
  assign wr_mis  = reg_wr && at(reg_addr, nicsc_pkg::OFF_MIS);
  assign run      = (st_ff == nicsc_pkg::ST_RUN);
  assign srst_on  = (st_ff == nicsc_pkg::ST_SRST);
  assign load_end = (st_ff == nicsc_pkg::ST_LOAD) && cnt_ff == 16'h0000;
  // A finished reload restores defaults like a hardware reset.
  assign clr_all  = sys_rst || load_end;

  // Soft reset and reload sequencer.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_ff  <= nicsc_pkg::ST_RUN;
      cnt_ff <= 16'h0000;
    end
    else
    begin
      case (st_ff)
        nicsc_pkg::ST_RUN:
        begin
          if (wr_cmd && reg_wdata[nicsc_pkg::C_RST])
          begin
            st_ff  <= nicsc_pkg::ST_SRST;
            cnt_ff <= 16'(nicsc_pkg::SRST_CYC - 1);
          end
          else if (wr_ee && reg_wdata[7:6] == nicsc_pkg::EE_LOAD)
          begin
            st_ff  <= nicsc_pkg::ST_LOAD;
            cnt_ff <= 16'(LOAD_CYCLES - 1);
          end
        end
        nicsc_pkg::ST_SRST:
        begin
          // The command bit reads one until this countdown ends.
          if (cnt_ff == 16'h0000)
            st_ff <= nicsc_pkg::ST_RUN;
          else
            cnt_ff <= cnt_ff - 16'h0001;
        end
        nicsc_pkg::ST_LOAD:
        begin
          if (cnt_ff == 16'h0000)
            st_ff <= nicsc_pkg::ST_RUN;
          else
            cnt_ff <= cnt_ff - 16'h0001;
        end
        default:
          st_ff <= nicsc_pkg::ST_RUN;
      endcase
    end
  end

  // One status word per descriptor; events are applied after the
  // software write so a completion in the same cycle is not lost.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_tsd
      always_comb
      begin
        nxt_tsd[g] = tsd_ff[g];
        if (wr_tsd && wr_idx == 2'(g))
          nxt_tsd[g] = reg_wdata & nicsc_pkg::TSD_WMASK;
        if (dma_done && dma_idx == 2'(g))
          nxt_tsd[g][nicsc_pkg::B_OWN] = 1'b1;
        if (tx_done && tx_idx == 2'(g))
        begin
          nxt_tsd[g][nicsc_pkg::B_CRS] = tsd_ff[g][nicsc_pkg::B_CRS]
                                         | tx_carrier_lost;
          nxt_tsd[g][nicsc_pkg::B_ABT] = tx_aborted;
          nxt_tsd[g][nicsc_pkg::B_OWC] = tx_late_coll;
          // Heartbeat has no meaning at 100 Mbps.
          nxt_tsd[g][nicsc_pkg::B_HB] = tx_hb_fail && !speed_100;
          nxt_tsd[g][27:24] = tx_coll_cnt;
          nxt_tsd[g][nicsc_pkg::B_TOK] = !tx_underrun
                                         && !tx_aborted;
          nxt_tsd[g][nicsc_pkg::B_TUN] = tx_underrun;
        end
      end

      // Soft reset keeps only the DMA done flag set.
      always_ff @(posedge ref_clk)
      begin
        if (clr_all || srst_on)
          tsd_ff[g] <= nicsc_pkg::TSD_RST;
        else
          tsd_ff[g] <= nxt_tsd[g];
      end

      // A long frame blocks the queue until its DMA is done.
      assign hold_v[g] = !tsd_ff[g][nicsc_pkg::B_OWN]
                         && tsd_ff[g][12:0] > nicsc_pkg::LONG_LIM;
    end
  endgenerate

  assign tx_queue_hold = |hold_v;

  // Start level: code zero is the minimum, else units of 32 bytes.
  // Software keeps the level within the FIFO size.
  logic [5:0]  lvl_code;
  logic [11:0] lvl_bytes;
  assign lvl_code  = tsd_ff[tx_cur_idx][21:16];
  assign lvl_bytes = (lvl_code == 6'h00) ? nicsc_pkg::START_MIN
                     : {1'b0, lvl_code, 5'h00};
  assign tx_start  = tx_path_on
                     && (tx_fifo_bytes >= lvl_bytes
                         || tx_frame_in_fifo);

  // Early threshold from fraction or, for unknown protocols, from
  // the length register; a zero code or length gives none.
  logic [16:0] frac_prod;
  logic [12:0] thr;
  logic        thr_on;
  logic        early_set;
  assign frac_prod = rx_frame_len * rx_early_fraction;
  assign thr    = rx_proto_known ? frac_prod[16:4]
                  : {1'b0, mis_ff[11:0]};
  assign thr_on = rx_proto_known ? (rx_early_fraction != 4'h0)
                  : (mis_ff[11:0] != 12'h000);
  assign early_set = rx_active && thr_on && !fired_ff
                     && rx_byte_cnt > thr;

  // Header status word of the completing frame.
  logic        rx_take;
  logic        runt_v;
  logic        long_v;
  logic        sym_v;
  logic        good_v;
  logic [15:0] hdr_word;
  assign rx_take = rx_done && rx_done_ready;
  assign runt_v  = rx_frame_len < nicsc_pkg::RUNT_LEN;
  assign long_v  = rx_frame_len > nicsc_pkg::OVER_LEN;
  assign sym_v   = rx_bad_symbol && speed_100;
  assign good_v  = !(runt_v || long_v || sym_v
                     || rx_crc_err || rx_align_err);
  // Broadcast wins, so both group flags never appear together.
  assign hdr_word = {rx_mcast && !rx_bcast, rx_ucast, rx_bcast,
                     7'h00, sym_v, runt_v, long_v,
                     rx_crc_err, rx_align_err, good_v};

  // Early flags: hardware set wins over a write-one clear, except
  // that completion clears the threshold flag.
  always_comb
  begin
    nxt_early_receive_flags = early_receive_flags_ff;
    if (wr_early_receive_flags)
      nxt_early_receive_flags = early_receive_flags_ff & ~reg_wdata[7:0];
    nxt_early_receive_flags[7:4] = 4'h0;
    if (rx_take && good_v)
      nxt_early_receive_flags[nicsc_pkg::E_GOOD] = 1'b1;
    if (rx_take && !good_v)
      nxt_early_receive_flags[nicsc_pkg::E_BAD] = 1'b1;
    if (rx_active && local_wr_ptr == host_read_pointer)
      nxt_early_receive_flags[nicsc_pkg::E_OVW] = 1'b1;
    if (early_set)
      nxt_early_receive_flags[nicsc_pkg::E_HIT] = 1'b1;
    if (rx_take)
      nxt_early_receive_flags[nicsc_pkg::E_HIT] = 1'b0;
  end

  // Early flag register.
  always_ff @(posedge ref_clk)
  begin
    if (clr_all || srst_on)
      early_receive_flags_ff <= nicsc_pkg::EARLY_RECEIVE_FLAGS_RST;
    else
      early_receive_flags_ff <= nxt_early_receive_flags;
  end

  // Per-frame early marker and receive interrupt pulses.
  always_ff @(posedge ref_clk)
  begin
    if (clr_all || srst_on)
    begin
      fired_ff <= 1'b0;
      ok_ff    <= 1'b0;
      err_ff   <= 1'b0;
    end
    else
    begin
      fired_ff <= (fired_ff || early_set) && !rx_take;
      ok_ff    <= early_set || (rx_take && good_v);
      err_ff   <= rx_take && !good_v;
    end
  end

  assign rx_ok_int  = ok_ff;
  assign rx_err_int = err_ff;

  // Two-entry header buffer so a stalled DMA loses no status word.
  assign rx_done_ready = (fill_ff != 2'h2);
  assign hdr_valid     = (fill_ff != 2'h0);
  assign hdr_status    = buf_ff[rp_ff];
  always_ff @(posedge ref_clk)
  begin
    if (clr_all || srst_on)
    begin
      wp_ff   <= 1'b0;
      rp_ff   <= 1'b0;
      fill_ff <= 2'h0;
      buf_ff[0] <= 16'h0000;
      buf_ff[1] <= 16'h0000;
    end
    else
    begin
      if (rx_take)
      begin
        buf_ff[wp_ff] <= hdr_word;
        wp_ff <= !wp_ff;
      end
      if (hdr_valid && hdr_ready)
        rp_ff <= !rp_ff;
      fill_ff <= fill_ff + 2'(rx_take)
                 - 2'(hdr_valid && hdr_ready);
    end
  end

  // Early interrupt length; software keeps the low two bits zero.
  always_ff @(posedge ref_clk)
  begin
    if (clr_all)
      mis_ff <= nicsc_pkg::MIS_RST;
    else if (wr_mis && reg_size == nicsc_pkg::SZ_BYTE)
      mis_ff <= {mis_ff[15:8], reg_wdata[7:0]};
    else if (wr_mis)
      mis_ff <= {4'h0, reg_wdata[11:0]};
  end

  // Path enables; soft reset turns both off.
  always_ff @(posedge ref_clk)
  begin
    if (clr_all || srst_on)
    begin
      rx_on_ff <= 1'b0;
      tx_on_ff <= 1'b0;
    end
    else if (wr_cmd && run)
    begin
      // A reset command drops both paths at the write edge itself, so
      // no path is live in the first soft reset cycle.
      rx_on_ff <= reg_wdata[nicsc_pkg::C_RX]
                  && !reg_wdata[nicsc_pkg::C_RST];
      tx_on_ff <= reg_wdata[nicsc_pkg::C_TX]
                  && !reg_wdata[nicsc_pkg::C_RST];
    end
  end

  // Prom mode and pin bits; writes are ignored during a reload.
  always_ff @(posedge ref_clk)
  begin
    if (clr_all)
    begin
      mode_ff <= nicsc_pkg::EE_NORMAL;
      pins_ff <= 3'h0;
    end
    else if (wr_ee && run)
    begin
      mode_ff <= reg_wdata[7:6];
      pins_ff <= reg_wdata[3:1];
    end
  end

  // Programming mode stops network and bus master activity.
  assign net_disable  = (mode_ff == nicsc_pkg::EE_PROG);
  assign cfg_write_en = (mode_ff == nicsc_pkg::EE_CFGWR);
  assign rx_path_on   = rx_on_ff && !net_disable;
  assign tx_path_on   = tx_on_ff && !net_disable;
  assign fifo_reinit  = srst_on;
  assign load_busy    = (st_ff == nicsc_pkg::ST_LOAD);
  assign prom_select  = net_disable && pins_ff[2];
  assign prom_clock   = net_disable && pins_ff[1];
  assign prom_in      = net_disable && pins_ff[0];

  // Registered read data; unmapped offsets read zero.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rdata_ff <= 32'h0000_0000;
    else if (reg_rd)
    begin
      if (reg_addr[7:4] == nicsc_pkg::OFF_TSD0[7:4])
        rdata_ff <= tsd_ff[reg_addr[3:2]];
      else if (at(reg_addr, nicsc_pkg::OFF_EARLY_RECEIVE_FLAGS))
        rdata_ff <= {24'h000000, early_receive_flags_ff};
      else if (at(reg_addr, nicsc_pkg::OFF_CMD))
        rdata_ff <= {27'h0000000, srst_on, rx_on_ff, tx_on_ff,
                     1'b0, rx_ring_empty};
      else if (at(reg_addr, nicsc_pkg::OFF_EE))
        // The prom data pin is only meaningful while software owns it.
        rdata_ff <= {24'h000000, mode_ff, 2'h0, pins_ff,
                     net_disable && prom_out};
      else if (at(reg_addr, nicsc_pkg::OFF_MIS))
        rdata_ff <= {16'h0000, mis_ff};
      else
        rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  tsd_wclr_a: assert property (wr_tsd && wr_idx == 2'h0 && run
    && !tx_done && !load_end |=> tsd_ff[0][31:24] == 8'h00
    && tsd_ff[0][15:14] == 2'h0) else $error("status not cleared");
  srst_own_a: assert property (srst_on
    |=> tsd_ff[1] == nicsc_pkg::TSD_RST) else $error("bad soft reset");
  tx_abort_a: assert property (tx_done && tx_idx == 2'h2
    && tx_aborted && run && !load_end |=> tsd_ff[2][30] && !tsd_ff[2][15])
    else $error("abort not flagged");
  tx_under_a: assert property (tx_done && tx_idx == 2'h0
    && tx_underrun && run && !load_end |=> tsd_ff[0][14] && !tsd_ff[0][15])
    else $error("underrun misreported");
  dma_own_a: assert property (dma_done && dma_idx == 2'h1
    && run && !load_end |=> tsd_ff[1][13]) else $error("own not set");
  tx_level_a: assert property (tx_path_on && lvl_code == 6'h00
    && tx_fifo_bytes >= 12'h008 |-> tx_start) else $error("no start");
  mis_zero_a: assert property (!rx_proto_known
    && mis_ff[11:0] == 12'h000 && !wr_mis |=> !$rose(early_receive_flags_ff[0]))
    else $error("early irq on zero length");
  hdr_excl_a: assert property (hdr_valid
    |-> !(hdr_status[15] && hdr_status[13])) else $error("mc and bc");
  good_flag_a: assert property (rx_take && good_v
    && run && !load_end |=> early_receive_flags_ff[3]) else $error("good not set");
  ovw_flag_a: assert property (rx_active && run && !load_end
    && local_wr_ptr == host_read_pointer |=> early_receive_flags_ff[1])
    else $error("overwrite not set");
  early_irq_a: assert property ($rose(early_receive_flags_ff[0])
    |-> rx_ok_int) else $error("early without interrupt");
  srst_seq_a: assert property (wr_cmd && reg_wdata[4] && run
    |=> (srst_on && !tx_on_ff && !rx_on_ff) [*4] ##1 run)
    else $error("soft reset length wrong");
  load_back_a: assert property (load_end
    |=> mode_ff == nicsc_pkg::EE_NORMAL && run) else $error("no return");
  prog_off_a: assert property (mode_ff == nicsc_pkg::EE_PROG
    |-> !rx_path_on && !tx_path_on) else $error("paths live in prog");

  tx_ok_c: cover property (tx_done && !tx_underrun ##1 tsd_ff[0][15]);
  hdr_stall_c: cover property (fill_ff == 2'h2 && !hdr_ready);
  load_done_c: cover property (load_end);

endmodule : nicsc_top

/* testbench/nicsc_far.sv */
// Far-side model: DMA sink for header words and serial prom data.
// Assumes one clock; the bench stalls the sink through hdr_stall.
`timescale 1ns/100ps
module nicsc_far (
  // Clock.
  input  wire logic        ref_clk,
  // Header word stream from the block.
  input  wire logic        hdr_valid,
  input  wire logic [15:0] hdr_status,
  input  wire logic        hdr_stall,
  output logic             hdr_ready,
  output logic      [15:0] last_hdr,
  // Serial prom pins.
  input  wire logic        prom_select,
  output logic             prom_out
);
  logic tog_ff = 1'b0;  // Changes every cycle when the prom is idle.
  // The sink accepts a word whenever it is not stalled.
  assign hdr_ready = !hdr_stall;
  // An unselected prom output never holds a stable level.
  assign prom_out = prom_select ? 1'b1 : tog_ff;
  // Keep the last word taken, so the bench sees what crossed.
  always_ff @(posedge ref_clk)
  begin
    tog_ff <= ~tog_ff;
    if (hdr_valid && hdr_ready)
      last_hdr <= hdr_status;
  end
endmodule : nicsc_far

/* testbench/testbench.sv */
// Register-level bench for the status and command block.
// Assumes nicsc_top and nicsc_far; inputs change on rising edges.
`timescale 1ns/100ps
module testbench;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, tx_done, tx_aborted;
  logic        tx_carrier_lost, tx_late_coll, tx_hb_fail, tx_underrun;
  logic        dma_done, speed_100, tx_frame_in_fifo, rx_active;
  logic        rx_proto_known, rx_ring_empty, rx_done, rx_mcast, rx_ucast;
  logic        rx_bcast, rx_bad_symbol, rx_crc_err, rx_align_err;
  logic        hdr_ready, prom_out, hdr_stall, tx_start, tx_queue_hold;
  logic        rx_done_ready, rx_ok_int, rx_err_int, hdr_valid, prom_in;
  logic        rx_path_on, tx_path_on, fifo_reinit, net_disable;
  logic        cfg_write_en, load_busy, prom_select, prom_clock;
  logic [1:0]  reg_size, tx_idx, dma_idx, tx_cur_idx;
  logic [3:0]  tx_coll_cnt, rx_early_fraction;
  logic [7:0]  reg_addr;
  logic [11:0] tx_fifo_bytes;
  logic [12:0] rx_byte_cnt, rx_frame_len;
  logic [15:0] local_wr_ptr, host_read_pointer, hdr_status, last_hdr;
  logic [31:0] reg_wdata, reg_rdata;
  int          n_fail, checked, i;
  localparam logic [1:0] DW = nicsc_pkg::SZ_DW;
  localparam logic [1:0] BY = nicsc_pkg::SZ_BYTE;

  // Reload shortened to 20 cycles to keep the run brief.
  nicsc_top #(.LOAD_CYCLES(20)) uut (.*);
  nicsc_far far (.*);

  // 50 ns clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Compare and count; a mismatch is reported at once.
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    if (g !== e)
      n_fail++;
  endtask : chk

  // One write access, held for exactly one sampling edge.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] s);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_size, reg_wdata} <= {1'b1, a, s, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One read access; data is checked half a cycle after the sampling edge.
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask : rd

  // Frame end plus DMA end on descriptor 0, flags as {crs,abt,owc,hb,ncc,und}.
  task txev(input logic [8:0] f);
    @(posedge ref_clk);
    {tx_done, dma_done, tx_carrier_lost, tx_aborted, tx_late_coll,
     tx_hb_fail, tx_coll_cnt, tx_underrun} <= {2'b11, f};
    @(posedge ref_clk);
    {tx_done, dma_done} <= 2'b00;
  endtask : txev

  // Print the counts, the verdict, and stop.
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  initial
  begin
    n_fail = 0;
    checked = 0;
    {reg_wr, reg_rd, reg_addr, reg_size, reg_wdata, tx_done, tx_idx,
     tx_carrier_lost, tx_aborted, tx_late_coll, tx_hb_fail, tx_coll_cnt,
     tx_underrun, dma_done, dma_idx, tx_fifo_bytes, tx_frame_in_fifo,
     tx_cur_idx, rx_active, rx_byte_cnt, rx_proto_known, rx_early_fraction,
     local_wr_ptr, rx_ring_empty, rx_done, rx_mcast, rx_ucast, rx_bcast,
     rx_bad_symbol, rx_crc_err, rx_align_err} <= '0;
    {sys_rst, speed_100, hdr_stall} <= 3'b111;
    host_read_pointer <= 16'h0100;
    rx_frame_len <= 13'h003C;  // Below 64 bytes: a runt.
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h10, 32'h0000_2000);
    rd(8'h36, 32'h0000_0000);
    // Size write, then a byte write that must be ignored.
    wr(8'h10, 32'h0000_05C0, DW);
    wr(8'h10, 32'hFFFF_FFFF, BY);
    rd(8'h10, 32'h0000_05C0);
    txev(9'h126);  // Carrier lost, heartbeat at 100 Mbps, three collisions.
    rd(8'h10, 32'h8300_A5C0);
    wr(8'h10, 32'hFFFF_05C0, DW);
    rd(8'h10, 32'h003F_05C0);
    txev(9'h001);  // Underrun.
    rd(8'h10, 32'h003F_65C0);
    wr(8'h10, 32'h0000_0800, DW);
    @(negedge ref_clk);
    chk(tx_queue_hold, 1'b1);
    txev(9'h0C0);  // Abort with late collision.
    rd(8'h10, 32'h6000_2800);
    chk(tx_queue_hold, 1'b0);
    wr(8'h37, 32'h0000_000C, BY);
    rd(8'h37, 32'h0000_000C);
    // Start level codes 0 and 1: 8 and 32 bytes.
    for (i = 0; i < 2; i++)
    begin
      wr(8'h10, {10'h0, i[5:0], 16'h0100}, DW);
      @(posedge ref_clk);
      tx_fifo_bytes <= (i == 0) ? 12'h007 : 12'h01F;
      @(negedge ref_clk);
      chk(tx_start, 1'b0);
      @(posedge ref_clk);
      tx_fifo_bytes <= tx_fifo_bytes + 12'h001;
      @(negedge ref_clk);
      chk(tx_start, 1'b1);
    end
    wr(8'h37, 32'h0000_0010, BY);
    rd(8'h37, 32'h0000_0010);
    repeat (8) @(posedge ref_clk);
    rd(8'h37, 32'h0000_0000);
    rd(8'h10, 32'h0000_2000);
    // Unknown protocol frame passes the length register threshold.
    wr(8'h5C, 32'h0000_0040, BY);
    @(posedge ref_clk);
    {rx_active, rx_byte_cnt} <= {1'b1, 13'h0041};
    repeat (3) @(posedge ref_clk);
    rx_active <= 1'b0;
    rd(8'h36, 32'h0000_0001);
    @(posedge ref_clk);
    {rx_done, rx_mcast, rx_bcast} <= 3'b111;
    @(posedge ref_clk);
    rx_done <= 1'b0;
    @(negedge ref_clk);
    chk(hdr_status, 32'h0000_2010);
    rd(8'h36, 32'h0000_0004);
    wr(8'h36, 32'h0000_0004, BY);
    rd(8'h36, 32'h0000_0000);
    // Good frame while the sink stalls fills the buffer.
    @(posedge ref_clk);
    {rx_done, rx_mcast, rx_bcast, rx_frame_len} <= {3'b100, 13'h0064};
    @(posedge ref_clk);
    rx_done <= 1'b0;
    @(negedge ref_clk);
    chk(rx_done_ready, 1'b0);
    @(posedge ref_clk);
    hdr_stall <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(last_hdr, 32'h0000_0001);
    // Pointers meet during a frame.
    @(posedge ref_clk);
    {rx_active, rx_byte_cnt, local_wr_ptr} <= {1'b1, 13'h0, 16'h0100};
    @(posedge ref_clk);
    rx_active <= 1'b0;
    rd(8'h36, 32'h0000_000A);
    wr(8'h36, 32'h0000_000A, BY);
    rd(8'h36, 32'h0000_0000);
    // Programming mode hands the prom pins to software.
    wr(8'h50, 32'h0000_008E, BY);
    @(negedge ref_clk);
    chk({net_disable, prom_select, prom_clock, prom_in}, 4'hF);
    rd(8'h50, 32'h0000_008F);
    wr(8'h50, 32'h0000_0040, BY);
    @(negedge ref_clk);
    i = 0;
    while (load_busy !== 1'b0 && i < 100)
    begin
      @(posedge ref_clk);
      i++;
    end
    chk(i > 15 && i < 22, 1'b1);
    @(negedge ref_clk);
    rd(8'h50, 32'h0000_0000);
    rd(8'h5C, 32'h0000_0000);
    wrap_up();
  end
endmodule : testbench
